//--- hw/pcf_pkg.sv
// package: register map, field layout, defaults and state encoding of the cache flush control
// Operation
// - A 4-bit writable group index sits in flush register bits 7:4.
// - Writing one to bit 1 invalidates the entries of the indexed group.
// - Group flush uses the group index as (part of) the set address.
// - Group flush exists only when group addressing capability is non-zero.
// - Group flush trigger returns to zero by itself when the flush ends.
// - Writing one to bit 0 invalidates the whole cache, ignoring the group.
// - Full flush trigger clears itself on completion; software may poll it.
// - Every flush updates the started and completed status flags.
// - Started flag sets at flush start, cleared only by writing one.
// - Completed flag sets at flush end, cleared only by writing one.
// - With group set addressing on, requester group joins the set address.
package pcf_pkg;
   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0]  PCF_ADDR_FLUSH  = 8'h14;
   localparam logic [7:0]  PCF_ADDR_CTRL   = 8'h10;
   localparam logic [7:0]  PCF_ADDR_STATUS = 8'h18;
   localparam logic [7:0]  PCF_ADDR_IMASK  = 8'h1C;
   localparam logic [7:0]  PCF_ADDR_CAP    = 8'h00;
   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int          PCF_FLUSH_ALL   = 0;
   localparam int          PCF_FLUSH_GRP   = 1;
   localparam int          PCF_FLUSH_SEL   = 4;
   localparam int          PCF_GRP_W       = 4;
   localparam int          PCF_CTRL_GADDR  = 4;
   localparam int          PCF_ST_STARTED  = 2;
   localparam int          PCF_ST_DONE     = 3;
   localparam int          PCF_CAP_LO      = 0;
   localparam logic [31:0] PCF_RESET_VAL   = 32'h0000_0000;
   localparam logic [3:0]  PCF_CAP_DEFAULT = 4'h1;
   localparam int          PCF_SET_W_DEF   = 6;
   // flush controller states
   typedef enum logic [1:0]
   {
      PCF_IDLE  = 2'b00,
      PCF_SWEEP = 2'b01,
      PCF_DONE  = 2'b10
   } pcf_state_t;
endpackage : pcf_pkg

//--- hw/pcf_set_sweep.sv
// set sweeper: walks the cache sets to invalidate, full or one group's
module pcf_set_sweep
   import pcf_pkg::*;
#(
   parameter int SET_W = pcf_pkg::PCF_SET_W_DEF
)
(
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset_n,
   input  wire logic                       clk_en,
   // request
   input  wire logic                       start,
   input  wire logic                       group_mode,
   input  wire logic [pcf_pkg::PCF_GRP_W-1:0] group_sel,
   // cache invalidate port
   output logic                            inv_valid,
   output logic [SET_W-1:0]                inv_set,
   output logic                            last
);
   localparam int LOW_W = SET_W - PCF_GRP_W;
   logic [LOW_W-1:0] cnt_ff;
   logic             busy_ff;
   logic [PCF_GRP_W-1:0] grp_ff;
   logic             mode_ff;

   // group sweep holds top bits at the group index, full sweep counts all bits
   assign inv_valid = busy_ff;
   assign inv_set   = {grp_ff, cnt_ff};
   assign last      = busy_ff && (&cnt_ff) && (mode_ff || (&grp_ff));

   // sweep counter
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         busy_ff <= 1'b0;
         cnt_ff  <= '0;
         grp_ff  <= '0;
         mode_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         if (start && !busy_ff)
         begin
            busy_ff <= 1'b1;
            cnt_ff  <= '0;
            mode_ff <= group_mode;
            grp_ff  <= group_mode ? group_sel : '0;
         end
         else if (busy_ff)
         begin
            if (last)
               busy_ff <= 1'b0;
            cnt_ff <= cnt_ff + 1'b1;
            if (!mode_ff && (&cnt_ff))
               grp_ff <= grp_ff + 1'b1;
         end
      end
   end
endmodule : pcf_set_sweep

//--- hw/pcf_flush_ctrl.sv
// top: flush register, status flags, interrupt mask and flush sequencing
module pcf_flush_ctrl
#(
   parameter int                       SET_W   = pcf_pkg::PCF_SET_W_DEF,
   parameter logic [3:0]               GRP_CAP = pcf_pkg::PCF_CAP_DEFAULT
)
(
   // clock, enable and reset
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   clk_en,
   // register port
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   // lookup side: requester group and set index
   input  wire logic [pcf_pkg::PCF_GRP_W-1:0] req_group,
   input  wire logic [SET_W-pcf_pkg::PCF_GRP_W-1:0] req_index,
   output logic [SET_W-1:0]            lookup_set,
   // cache invalidate port
   output logic                        inv_valid,
   output logic [SET_W-1:0]            inv_set,
   // interrupt
   output logic                        irq
);
   import pcf_pkg::*;

   // ****************************************************************
   // state
   // ****************************************************************
   logic                 full_trig_ff;
   logic                 grp_trig_ff;
   logic [PCF_GRP_W-1:0] grp_sel_ff;
   logic                 grp_addr_en_ff;
   logic                 started_ff;
   logic                 done_ff;
   logic                 mask_started_ff;
   logic                 mask_done_ff;
   logic [31:0]          rdata_ff;
   pcf_state_t           state_ff;
   logic                 sweep_start;
   logic                 sweep_last;
   logic                 flush_begin;
   logic                 flush_end;
   logic                 wr_flush;
   logic                 wr_status;
   logic                 cap_has_group;

   assign wr_flush      = reg_wr && (reg_addr == PCF_ADDR_FLUSH);
   assign wr_status     = reg_wr && (reg_addr == PCF_ADDR_STATUS);
   assign cap_has_group = (GRP_CAP != 4'h0);

   // ****************************************************************
   // flush register
   // ****************************************************************
   // triggers only set on a written one; cleared by hardware at flush end
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         full_trig_ff <= PCF_RESET_VAL[PCF_FLUSH_ALL];
         grp_trig_ff  <= PCF_RESET_VAL[PCF_FLUSH_GRP];
         grp_sel_ff   <= PCF_RESET_VAL[PCF_FLUSH_SEL +: PCF_GRP_W];
      end
      else if (clk_en)
      begin
         if (wr_flush)
            grp_sel_ff <= reg_wdata[PCF_FLUSH_SEL +: PCF_GRP_W];
         if (flush_end)
         begin
            full_trig_ff <= 1'b0;
            grp_trig_ff  <= 1'b0;
         end
         else if (wr_flush && state_ff == PCF_IDLE)
         begin
            // zero writes leave a pending trigger untouched
            if (reg_wdata[PCF_FLUSH_ALL])
               full_trig_ff <= 1'b1;
            if (reg_wdata[PCF_FLUSH_GRP] && cap_has_group)
               grp_trig_ff <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // control bit (group set addressing) and interrupt mask
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         grp_addr_en_ff  <= 1'b0;
         mask_started_ff <= 1'b0;
         mask_done_ff    <= 1'b0;
      end
      else if (clk_en)
      begin
         if (reg_wr && reg_addr == PCF_ADDR_CTRL)
            grp_addr_en_ff <= reg_wdata[PCF_CTRL_GADDR] && cap_has_group;
         if (reg_wr && reg_addr == PCF_ADDR_IMASK)
         begin
            mask_started_ff <= reg_wdata[PCF_ST_STARTED];
            mask_done_ff    <= reg_wdata[PCF_ST_DONE];
         end
      end
   end

   // ****************************************************************
   // flush sequencer
   // ****************************************************************
   // a group request while group addressing is off is still swept; software
   // must avoid it since other groups' aliases could stay valid
   assign sweep_start = (state_ff == PCF_IDLE) && (full_trig_ff || grp_trig_ff);
   assign flush_begin = sweep_start;
   assign flush_end   = (state_ff == PCF_DONE);

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         state_ff <= PCF_IDLE;
      else if (clk_en)
      begin
         case (state_ff)
            PCF_IDLE:
               if (sweep_start)
                  state_ff <= PCF_SWEEP;
            PCF_SWEEP:
               if (sweep_last)
                  state_ff <= PCF_DONE;
            PCF_DONE:
               state_ff <= PCF_IDLE;
            default:
               state_ff <= PCF_IDLE;
         endcase
      end
   end

   // full flush wins when both triggers are set
   pcf_set_sweep #(
      .SET_W      (SET_W)
   ) u_sweep (
      .clk        (clk),
      .reset_n    (reset_n),
      .clk_en     (clk_en),
      .start      (sweep_start),
      .group_mode (!full_trig_ff),
      .group_sel  (grp_sel_ff),
      .inv_valid  (inv_valid),
      .inv_set    (inv_set),
      .last       (sweep_last)
   );

   // ****************************************************************
   // lookup set address
   // ****************************************************************
   // without group addressing the top bits are plain index zero
   assign lookup_set = grp_addr_en_ff ? {req_group, req_index}
                                : {{PCF_GRP_W{1'b0}}, req_index};

   // ****************************************************************
   // status flags: set wins over write-one-to-clear
   // ****************************************************************
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         started_ff <= 1'b0;
         done_ff    <= 1'b0;
      end
      else if (clk_en)
      begin
         if (flush_begin)
            started_ff <= 1'b1;
         else if (wr_status && reg_wdata[PCF_ST_STARTED])
            started_ff <= 1'b0;
         if (flush_end)
            done_ff <= 1'b1;
         else if (wr_status && reg_wdata[PCF_ST_DONE])
            done_ff <= 1'b0;
      end
   end

   // level interrupt while an unmasked flag stands
   assign irq = (started_ff && mask_started_ff) || (done_ff && mask_done_ff);

   // ****************************************************************
   // read port
   // ****************************************************************
   // unmapped addresses and reserved bits read as zero
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         rdata_ff <= '0;
      else if (clk_en)
      begin
         rdata_ff <= '0;
         if (reg_rd)
         begin
            case (reg_addr)
               PCF_ADDR_FLUSH:
               begin
                  rdata_ff[PCF_FLUSH_ALL]                 <= full_trig_ff;
                  rdata_ff[PCF_FLUSH_GRP]                 <= grp_trig_ff;
                  rdata_ff[PCF_FLUSH_SEL +: PCF_GRP_W]    <= grp_sel_ff;
               end
               PCF_ADDR_CTRL:
                  rdata_ff[PCF_CTRL_GADDR] <= grp_addr_en_ff;
               PCF_ADDR_STATUS:
               begin
                  rdata_ff[PCF_ST_STARTED] <= started_ff;
                  rdata_ff[PCF_ST_DONE]    <= done_ff;
               end
               PCF_ADDR_IMASK:
               begin
                  rdata_ff[PCF_ST_STARTED] <= mask_started_ff;
                  rdata_ff[PCF_ST_DONE]    <= mask_done_ff;
               end
               PCF_ADDR_CAP:
                  rdata_ff[PCF_CAP_LO +: $bits(GRP_CAP)] <= GRP_CAP;
               default:
                  rdata_ff <= '0;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_ff;
endmodule : pcf_flush_ctrl

//--- test/pcf_flush_props.sv
// checker: flush sequencing and register port properties
module pcf_flush_props
   import pcf_pkg::*;
#(
   parameter int         SET_W   = pcf_pkg::PCF_SET_W_DEF,
   parameter logic [3:0] GRP_CAP = pcf_pkg::PCF_CAP_DEFAULT
)
(
   // clock and reset
   input wire logic                                  clk,
   input wire logic                                  reset_n,
   input wire logic                                  clk_en,
   // register port
   input wire logic [7:0]                            reg_addr,
   input wire logic [31:0]                           reg_wdata,
   input wire logic                                  reg_wr,
   input wire logic                                  reg_rd,
   input wire logic [31:0]                           reg_rdata,
   // lookup and invalidate side
   input wire logic [pcf_pkg::PCF_GRP_W-1:0]         req_group,
   input wire logic [SET_W-pcf_pkg::PCF_GRP_W-1:0]   req_index,
   input wire logic [SET_W-1:0]                      lookup_set,
   input wire logic                                  inv_valid,
   input wire logic [SET_W-1:0]                      inv_set,
   input wire logic                                  irq
);
   // ********************
   // helper: sweep length
   // ********************
   localparam int FULL_N = 2 ** SET_W;
   localparam int GRP_N  = 2 ** (SET_W - PCF_GRP_W);
   logic [15:0] run_ff;
   logic        gaddr_ff;
   // a group trigger only counts when the capability is built in
   wire logic   trig_wr = reg_wr && clk_en && reg_addr == PCF_ADDR_FLUSH
                          && (reg_wdata[0] || (reg_wdata[1] && GRP_CAP != 4'h0));
   // expected group addressing enable, tracked from control writes
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         gaddr_ff <= 1'b0;
      else if (clk_en && reg_wr && reg_addr == PCF_ADDR_CTRL)
         gaddr_ff <= reg_wdata[PCF_CTRL_GADDR] && (GRP_CAP != 4'h0);
   end
   // counts consecutive invalidate cycles
   always_ff @(posedge clk)
   begin
      if (!reset_n || !inv_valid)
         run_ff <= 16'h0000;
      else
         run_ff <= run_ff + 16'h0001;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_rd_idle; $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   property p_rsv; $past(reg_rd && clk_en && reg_addr == PCF_ADDR_FLUSH)
      |-> reg_rdata[31:8] == 24'h0 && reg_rdata[3:2] == 2'b00; endproperty
   property p_lookup; lookup_set[SET_W-PCF_GRP_W-1:0] == req_index
      && lookup_set[SET_W-1 -: PCF_GRP_W] == (gaddr_ff ? req_group : 4'h0); endproperty
   property p_start; $rose(inv_valid) |-> $past(trig_wr, 2); endproperty
   property p_len; $fell(inv_valid) |-> run_ff == FULL_N || run_ff == GRP_N; endproperty
   property p_step; inv_valid && $past(inv_valid) |-> inv_set == $past(inv_set) + 1'b1;
   endproperty
   property p_full0; $rose(inv_valid) && $past(reg_wdata[PCF_FLUSH_ALL], 2) |-> inv_set == '0;
   endproperty
   property p_grp; $rose(inv_valid) && !$past(reg_wdata[PCF_FLUSH_ALL], 2)
      |-> inv_set == {$past(reg_wdata[7:4], 2), {(SET_W-PCF_GRP_W){1'b0}}}; endproperty
   property p_busy; $past(reg_rd && clk_en && reg_addr == PCF_ADDR_FLUSH && inv_valid)
      |-> reg_rdata[1:0] != 2'b00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   a_rsv: assert property (p_rsv) else $error("reserved flush bits nonzero");
   a_lookup: assert property (p_lookup) else $error("lookup index lost");
   a_start: assert property (p_start) else $error("sweep without trigger");
   a_len: assert property (p_len) else $error("sweep length wrong");
   a_step: assert property (p_step) else $error("sweep skipped a set");
   a_full0: assert property (p_full0) else $error("full sweep not from zero");
   a_grp: assert property (p_grp) else $error("group sweep wrong sets");
   a_busy: assert property (p_busy) else $error("trigger cleared early");
   c_full: cover property ($fell(inv_valid) && run_ff == FULL_N);
   c_grp: cover property ($fell(inv_valid) && run_ff == GRP_N);
   c_irq: cover property ($rose(irq));
endmodule : pcf_flush_props

bind pcf_flush_ctrl pcf_flush_props #(.SET_W(SET_W), .GRP_CAP(GRP_CAP)) u_props
(
   .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .req_group(req_group), .req_index(req_index), .lookup_set(lookup_set),
   .inv_valid(inv_valid),
   .inv_set(inv_set), .irq(irq)
);

//--- test/tb.sv
// testbench: register-driven flush sequences with self-checking reads
module tb
   import pcf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ********************
   // signals
   // ********************
   localparam int SW = 5;
   logic          clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0]    reg_addr  = 8'h00;
   logic [31:0]   reg_wdata = 32'h0, reg_rdata, q;
   logic [3:0]    req_group = 4'hA;
   logic [SW-5:0] req_index = 1'b1;
   logic [SW-1:0] lookup_set, inv_set;
   logic          inv_valid, irq;
   int            n_fail = 0, n_tests = 0, inv_cnt = 0, c0;
   always #5 clk = ~clk;
   // invalidate cycle counter, compared as differences only
   always @(posedge clk)
   begin
      if (inv_valid === 1'b1)
         inv_cnt <= inv_cnt + 1;
   end
   pcf_flush_ctrl #(.SET_W(SW), .GRP_CAP(4'h1)) dut
   (
      .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .req_group(req_group), .req_index(req_index), .lookup_set(lookup_set),
      .inv_valid(inv_valid), .inv_set(inv_set), .irq(irq)
   );
   // ********************
   // bus tasks
   // ********************
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_tests++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: %s", $time, msg);
         n_fail++;
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
      rd(a, q);
      chk(q, exp, msg);
   endtask : rdc
   // trigger, poll the trigger bits, then check the sweep length
   task flush(input logic [31:0] d, input int n, input string msg);
      c0 = inv_cnt;
      wr(PCF_ADDR_FLUSH, d);
      repeat (100)
      begin
         rd(PCF_ADDR_FLUSH, q);
         if (q[1:0] === 2'b00)
            break;
      end
      chk({30'h0, q[1:0]}, 32'h0, "trigger not cleared");
      chk(inv_cnt - c0, n, msg);
   endtask : flush
   task end_sim;
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // ********************
   // tests
   // ********************
   initial
   begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rdc(PCF_ADDR_FLUSH, 32'h0, "flush reset");
      rdc(PCF_ADDR_STATUS, 32'h0, "status reset");
      rdc(8'h2C, 32'h0, "unmapped read");
      rdc(PCF_ADDR_CAP, 32'h1, "capability field");
      wr(PCF_ADDR_FLUSH, 32'hFFFF_FFFC);
      rdc(PCF_ADDR_FLUSH, 32'h0000_00F0, "group select");
      rdc(PCF_ADDR_STATUS, 32'h0, "zero trigger started");
      $display("test registers done");
      // a write while the clock enable is low must leave the mask alone
      @(posedge clk);
      clk_en <= 1'b0;
      wr(PCF_ADDR_IMASK, 32'hC);
      clk_en <= 1'b1;
      rdc(PCF_ADDR_IMASK, 32'h0, "write while frozen");
      wr(PCF_ADDR_IMASK, 32'hC);
      flush(32'h71, 32, "full flush length");
      rdc(PCF_ADDR_STATUS, 32'hC, "flags after full");
      chk({31'h0, irq}, 32'h1, "irq not raised");
      wr(PCF_ADDR_STATUS, 32'h0);
      rdc(PCF_ADDR_STATUS, 32'hC, "zero write cleared");
      wr(PCF_ADDR_STATUS, 32'h4);
      rdc(PCF_ADDR_STATUS, 32'h8, "started not cleared");
      wr(PCF_ADDR_STATUS, 32'h8);
      rdc(PCF_ADDR_STATUS, 32'h0, "completed not cleared");
      chk({31'h0, irq}, 32'h0, "irq stuck");
      $display("test full flush done");
      wr(PCF_ADDR_IMASK, 32'h0);
      wr(PCF_ADDR_CTRL, 32'h10);
      flush(32'h52, 2, "group flush length");
      rdc(PCF_ADDR_FLUSH, 32'h50, "group trigger kept");
      rdc(PCF_ADDR_STATUS, 32'hC, "flags after group");
      chk({31'h0, irq}, 32'h0, "masked irq raised");
      #1 chk(32'(lookup_set), 32'h15, "lookup with group");
      wr(PCF_ADDR_CTRL, 32'h0);
      #1 chk(32'(lookup_set), 32'h01, "lookup without group");
      wr(PCF_ADDR_CTRL, 32'h10);
      flush(32'h32, 2, "second group flush");
      $display("test group flush done");
      flush(32'h3, 32, "both triggers");
      wr(PCF_ADDR_FLUSH, 32'h1);
      flush(32'h2, 32, "trigger while busy");
      rdc(PCF_ADDR_FLUSH, 32'h0, "refused trigger select");
      $display("test back to back done");
      end_sim();
   end
   // watchdog well beyond the expected run
   initial
   begin
      #300000;
      n_fail++;
      end_sim();
   end
endmodule : tb
